// [src/ckgen_regs.svh]
// Register offsets, field positions, reset values and timing counts
// for the clock generation unit. Definitions only; include by name.
`ifndef CKGEN_REGS_SVH
`define CKGEN_REGS_SVH

// Byte offsets on the APB register bus
`define CKGEN_OFF_SYNTH    8'h00
`define CKGEN_OFF_REFDIV   8'h04
`define CKGEN_OFF_POST_DIVIDER_FIELD  8'h08
`define CKGEN_OFF_PLLCTL   8'h0c
`define CKGEN_OFF_TRIM_HI  8'h10
`define CKGEN_OFF_TRIM_LO  8'h14
`define CKGEN_OFF_OSCCTL   8'h18
`define CKGEN_OFF_CLKSEL   8'h1c
`define CKGEN_OFF_GUARD    8'h20
`define CKGEN_OFF_STATUS   8'h24
`define CKGEN_OFF_IRQ_FLG  8'h28
`define CKGEN_OFF_IRQ_MSK  8'h2c
`define CKGEN_OFF_DBGDIV   8'h30

// Field positions
`define CKGEN_OSC_EN_BIT   7
`define CKGEN_FILT_MSB     4
`define CKGEN_PLL_SELECT_BIT   0
`define CKGEN_GUARD_BIT    0
`define CKGEN_IRQ_LOCKLOST 0
`define CKGEN_IRQ_QUALUP   1
`define CKGEN_IRQ_QUALLOST 2

// Reset values: 2 x 1 MHz x (31+1) = 64 MHz VCO, /(3+1) = 16 MHz PLL
`define CKGEN_SYNTH_RST    6'h1f
`define CKGEN_REFDIV_RST   4'h0
`define CKGEN_POST_DIVIDER_FIELD_RST  5'h03
`define CKGEN_PLLCTL_RST   2'h0
`define CKGEN_TRIM_RST     16'h0200
`define CKGEN_OSCCTL_RST   8'h00
`define CKGEN_DBGDIV_RST   4'h2
`define CKGEN_IRC_NOM_KHZ  1000

// Timing: break gap of the clock switch, in ns, and in pclk cycles
`define CKGEN_PCLK_NS      100
`define CKGEN_GAP_NS       200
`define CKGEN_GAP_CYC      ((`CKGEN_GAP_NS + `CKGEN_PCLK_NS - 1) / `CKGEN_PCLK_NS)
`define CKGEN_QUAL_EDGES   8

`endif

// [src/ckgen_pkg.sv]
// Types shared by the clock generation unit, its checker and its bench.
// Assumes ckgen_regs.svh supplies the numeric constants.
package ckgen_pkg;

    // PLL configuration that travels to the analog PLL as one bundle
    typedef struct packed {
        logic [5:0] synth_mult;
        logic [3:0] ref_div;
        logic [4:0] post_div;
        logic [1:0] pll_ctrl;
    } ckgen_pll_cfg_t;

    // System clock switch states
    typedef enum logic [1:0] {
        CKGEN_SW_PLL     = 2'b00,
        CKGEN_SW_GAP_OSC = 2'b01,
        CKGEN_SW_OSC     = 2'b10,
        CKGEN_SW_GAP_PLL = 2'b11
    } ckgen_sw_state_t;

endpackage

// [src/ckgen_spike_filter.sv]
// Adaptive spike filter: qualifies the oscillator against the VCO.
// Assumes osc_sync and vco_sync are already two-flop synchronised.
`timescale 1ns/1ns
module ckgen_spike_filter #(
    parameter int QUAL_EDGES = 8,
    parameter int CW         = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pclk_en,
    input  wire logic       enable,
    input  wire logic       pll_locked,
    input  wire logic       osc_sync,
    input  wire logic       vco_sync,
    input  wire logic [4:0] half_ratio,
    output logic            osc_clean,
    output logic            qualified
);
    logic          osc_d;
    logic          vco_d;
    logic [CW-1:0] vco_cnt;
    logic [7:0]    good_cnt;
    logic          osc_edge;
    logic          vco_edge;
    logic          accept;
    logic          run;
    logic [CW-1:0] limit;

    ////////////////////////////////////////////////////////////////////
    // Edges of the synchronised inputs
    assign osc_edge = osc_sync ^ osc_d;
    assign vco_edge = vco_sync & ~vco_d;
    // Filter only acts with the external reference and a locked VCO
    assign run      = enable & pll_locked;
    // A half period shorter than the set VCO count is a spike
    assign accept   = osc_edge &
                      (vco_cnt + CW'(1) >= CW'(half_ratio));
    // No edge for four expected half periods plus four VCO edges means a dead oscillator
    assign limit    = CW'({half_ratio, 2'b00}) + CW'(4);

    // Edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d <= 1'b0;
            vco_d <= 1'b0;
        end else if (pclk_en) begin
            osc_d <= osc_sync;
            vco_d <= vco_sync;
        end
    end

    // VCO edges counted since the last accepted oscillator edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_cnt <= '0;
        end else if (pclk_en) begin
            if (!run || accept) begin
                vco_cnt <= '0;
            end else if (vco_edge && vco_cnt != limit) begin
                vco_cnt <= vco_cnt + CW'(1);
            end
        end
    end

    // Clean oscillator: toggles on accepted edges only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_clean <= 1'b0;
        end else if (pclk_en) begin
            if (!run) begin
                osc_clean <= 1'b0;
            end else if (accept) begin
                osc_clean <= ~osc_clean;
            end
        end
    end

    // Qualification: a run of good edges; lock loss drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            good_cnt  <= '0;
            qualified <= 1'b0;
        end else if (pclk_en) begin
            if (!run || vco_cnt == limit) begin
                good_cnt  <= '0;
                qualified <= 1'b0;
            end else if (accept) begin
                if (good_cnt == 8'(QUAL_EDGES)) begin
                    qualified <= 1'b1;
                end else begin
                    good_cnt <= good_cnt + 8'h01;
                end
            end
        end
    end

endmodule

// [src/ckgen_top.sv]
// Clock generation unit: registers, reference and mode control,
// glitch-free system clock switch, spike filter hookup.
// Assumes an APB master on pclk; the oscillator, VCO and PLL lock
// arrive as asynchronous pins and are synchronised here.
//
// Contract
// - After reset, system clock is PLL with the internal reference.
// - Internal reference runs at nominal 1 MHz by default.
// - External oscillator stays off until software sets its enable.
// - Spike filter acts only with the external oscillator enabled and the PLL locked.
// - Debug clock comes from PLL output, default 8 MHz.
// - A guard register protects the PLL, trim and oscillator control registers; post divider, clock select and debug divider stay writable.
// - Software may rewrite high and low trim of the internal reference.
// - Spike filter is digital, removes noise, and qualifies the oscillator.
// - In bypassed external mode the PLL stays enabled and locked.
// - CAN clock comes only from the external oscillator.
// - Default PLL: 64 MHz VCO, post divider 3, 16 MHz, bus 8 MHz.
// - Losing PLL lock also clears oscillator qualified status.
// - Losing qualification in bypassed mode sets PLL select again.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "ckgen_regs.svh"
module ckgen_top #(
    parameter int          QUAL_EDGES = `CKGEN_QUAL_EDGES,
    parameter logic [15:0] TRIM_RST   = `CKGEN_TRIM_RST
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     pclk_en,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     osc_clock_in,
    input  wire logic                     vco_clock_in,
    input  wire logic                     pll_lock_in,
    output ckgen_pkg::ckgen_pll_cfg_t     pll_cfg,
    output logic                          pll_enable,
    output logic                          pll_ref_ext,
    output logic                          osc_enable,
    output logic      [15:0]              internal_ref_trim,
    output logic                          sysclk_pll_en,
    output logic                          sysclk_osc_en,
    output logic      [3:0]               debug_clk_div,
    output logic                          can_clk_en,
    output logic                          osc_clean,
    output logic                          irq
);
    import ckgen_pkg::*;
    localparam int GAP_CYC = `CKGEN_GAP_CYC;
    logic [2:0]      sync1_reg;
    logic [2:0]      sync2_reg;
    logic            lock_d_reg;
    logic            qual_d_reg;
    logic [7:0]      trim_hi_reg;
    logic [7:0]      trim_lo_reg;
    logic [7:0]      osc_ctl_reg;
    logic            pll_sel_reg;
    logic            guard_reg;
    logic [2:0]      flag_reg;
    logic [2:0]      mask_reg;
    logic [1:0]      gap_reg;
    ckgen_sw_state_t sw_reg;
    ckgen_sw_state_t sw_next;
    logic            qualified;
    logic            filt_clean;
    logic            wr_en;
    logic            wr_guarded;
    logic [2:0]      events;
    logic [31:0]     rd_val;

    ////////////////////////////////////////////////////////////////////
    // Address map; used only for the error answer (pslverr)
    function automatic logic ckgen_mapped(input logic [7:0] a);
        case (a)
            `CKGEN_OFF_SYNTH, `CKGEN_OFF_REFDIV, `CKGEN_OFF_POST_DIVIDER_FIELD,
            `CKGEN_OFF_PLLCTL, `CKGEN_OFF_TRIM_HI, `CKGEN_OFF_TRIM_LO,
            `CKGEN_OFF_OSCCTL, `CKGEN_OFF_CLKSEL, `CKGEN_OFF_GUARD,
            `CKGEN_OFF_STATUS, `CKGEN_OFF_IRQ_FLG, `CKGEN_OFF_IRQ_MSK,
            `CKGEN_OFF_DBGDIV: ckgen_mapped = 1'b1;
            default:           ckgen_mapped = 1'b0;
        endcase
    endfunction

    // Registers behind the guard
    function automatic logic ckgen_guarded(input logic [7:0] a);
        case (a)
            `CKGEN_OFF_SYNTH, `CKGEN_OFF_REFDIV, `CKGEN_OFF_PLLCTL,
            `CKGEN_OFF_TRIM_HI, `CKGEN_OFF_TRIM_LO,
            `CKGEN_OFF_OSCCTL: ckgen_guarded = 1'b1;
            default:           ckgen_guarded = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: osc, vco, lock; stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else if (pclk_en) begin
            sync1_reg <= {pll_lock_in, vco_clock_in, osc_clock_in};
            sync2_reg <= sync1_reg;
        end
    end

    // Spike filter; enabled only while the oscillator enable bit is set
    ckgen_spike_filter #(
        .QUAL_EDGES (QUAL_EDGES),
        .CW         (8)
    ) u_filter (
        .pclk       (pclk),
        .presetn    (presetn),
        .pclk_en    (pclk_en),
        .enable     (osc_ctl_reg[`CKGEN_OSC_EN_BIT]),
        .pll_locked (sync2_reg[2]),
        .osc_sync   (sync2_reg[0]),
        .vco_sync   (sync2_reg[1]),
        .half_ratio (osc_ctl_reg[`CKGEN_FILT_MSB:0]),
        .osc_clean  (filt_clean),
        .qualified  (qualified)
    );

    ////////////////////////////////////////////////////////////////////
    // APB: answer in the first access cycle, write at that edge
    assign wr_en      = pclk_en & psel & penable & pready & pwrite;
    // Writes to guarded registers are dropped while guarded
    assign wr_guarded = wr_en & ~(guard_reg & ckgen_guarded(paddr));
    // Read mux; unmapped offsets read zero
    always_comb begin
        case (paddr)
            `CKGEN_OFF_SYNTH:   rd_val = {26'h0, pll_cfg.synth_mult};
            `CKGEN_OFF_REFDIV:  rd_val = {28'h0, pll_cfg.ref_div};
            `CKGEN_OFF_POST_DIVIDER_FIELD: rd_val = {27'h0, pll_cfg.post_div};
            `CKGEN_OFF_PLLCTL:  rd_val = {30'h0, pll_cfg.pll_ctrl};
            `CKGEN_OFF_TRIM_HI: rd_val = {24'h0, trim_hi_reg};
            `CKGEN_OFF_TRIM_LO: rd_val = {24'h0, trim_lo_reg};
            `CKGEN_OFF_OSCCTL:  rd_val = {24'h0, osc_ctl_reg};
            `CKGEN_OFF_CLKSEL:  rd_val = {31'h0, pll_sel_reg};
            `CKGEN_OFF_GUARD:   rd_val = {31'h0, guard_reg};
            `CKGEN_OFF_STATUS:  rd_val = {26'h0, sw_reg, pll_ref_ext,
                                          pll_sel_reg, qualified,
                                          sync2_reg[2]};
            `CKGEN_OFF_IRQ_FLG: rd_val = {29'h0, flag_reg};
            `CKGEN_OFF_IRQ_MSK: rd_val = {29'h0, mask_reg};
            `CKGEN_OFF_DBGDIV:  rd_val = {28'h0, debug_clk_div};
            default:            rd_val = 32'h0;
        endcase
    end

    // Answer registered in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (pclk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~ckgen_mapped(paddr);
            if (psel && !penable && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PLL configuration; resets to 64 MHz VCO, 16 MHz PLL clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cfg.synth_mult <= `CKGEN_SYNTH_RST;
            pll_cfg.ref_div    <= `CKGEN_REFDIV_RST;
            pll_cfg.post_div   <= `CKGEN_POST_DIVIDER_FIELD_RST;
            pll_cfg.pll_ctrl   <= `CKGEN_PLLCTL_RST;
        end else if (wr_guarded) begin
            case (paddr)
                `CKGEN_OFF_SYNTH:   pll_cfg.synth_mult <= pwdata[5:0];
                `CKGEN_OFF_REFDIV:  pll_cfg.ref_div    <= pwdata[3:0];
                `CKGEN_OFF_POST_DIVIDER_FIELD: pll_cfg.post_div   <= pwdata[4:0];
                `CKGEN_OFF_PLLCTL:  pll_cfg.pll_ctrl   <= pwdata[1:0];
                default:            ;
            endcase
        end
    end

    // Internal reference trim; factory value at reset, 1 MHz nominal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_hi_reg <= 8'(TRIM_RST >> 8);
            trim_lo_reg <= TRIM_RST[7:0];
        end else if (wr_guarded) begin
            if (paddr == `CKGEN_OFF_TRIM_HI) begin
                trim_hi_reg <= pwdata[7:0];
            end
            if (paddr == `CKGEN_OFF_TRIM_LO) begin
                trim_lo_reg <= pwdata[7:0];
            end
        end
    end
    // Oscillator control; off from reset until software enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctl_reg <= `CKGEN_OSCCTL_RST;
        end else if (wr_guarded && paddr == `CKGEN_OFF_OSCCTL) begin
            osc_ctl_reg <= pwdata[7:0];
        end
    end

    // Guard, debug divider and interrupt mask (unguarded)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_reg     <= 1'b0;
            debug_clk_div <= `CKGEN_DBGDIV_RST;
            mask_reg      <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                `CKGEN_OFF_GUARD:   guard_reg <= pwdata[`CKGEN_GUARD_BIT];
                `CKGEN_OFF_DBGDIV:  debug_clk_div <= pwdata[3:0];
                `CKGEN_OFF_IRQ_MSK: mask_reg <= pwdata[2:0];
                default:            ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PLL select: software may leave the PLL only once qualified;
    // loss of qualification forces it back and beats a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_sel_reg <= 1'b1;
        end else if (pclk_en) begin
            if (!qualified) begin
                pll_sel_reg <= 1'b1;
            end else if (wr_en && paddr == `CKGEN_OFF_CLKSEL) begin
                pll_sel_reg <= pwdata[`CKGEN_PLL_SELECT_BIT];
            end
        end
    end

    // Event history for the interrupt flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_d_reg <= 1'b0;
            qual_d_reg <= 1'b0;
        end else if (pclk_en) begin
            lock_d_reg <= sync2_reg[2];
            qual_d_reg <= qualified;
        end
    end

    assign events = {qual_d_reg & ~qualified,
                     ~qual_d_reg & qualified,
                     lock_d_reg & ~sync2_reg[2]};

    // Sticky flags, write one to clear; a new event wins the clear.
    // The level interrupt sees this cycle's events, one edge early.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 3'h0;
            irq      <= 1'b0;
        end else if (pclk_en) begin
            irq <= |((flag_reg | events) & mask_reg);
            if (wr_en && paddr == `CKGEN_OFF_IRQ_FLG) begin
                flag_reg <= (flag_reg & ~pwdata[2:0]) | events;
            end else begin
                flag_reg <= flag_reg | events;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock switch: break-before-make with a gap, so neither gated
    // clock is cut mid-phase. The gap costs a few cycles of no clock.
    always_comb begin
        sw_next = sw_reg;
        case (sw_reg)
            CKGEN_SW_PLL: sw_next = pll_sel_reg ? CKGEN_SW_PLL
                                                : CKGEN_SW_GAP_OSC;
            CKGEN_SW_OSC: sw_next = pll_sel_reg ? CKGEN_SW_GAP_PLL
                                                : CKGEN_SW_OSC;
            CKGEN_SW_GAP_OSC, CKGEN_SW_GAP_PLL: begin
                if (gap_reg == 2'(GAP_CYC - 1)) begin
                    sw_next = pll_sel_reg ? CKGEN_SW_PLL : CKGEN_SW_OSC;
                end
            end
            default: sw_next = CKGEN_SW_PLL;
        endcase
    end
    // Switch state and gap counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reg  <= CKGEN_SW_PLL;
            gap_reg <= 2'h0;
        end else if (pclk_en) begin
            sw_reg  <= sw_next;
            gap_reg <= (sw_next == sw_reg) ? gap_reg + 2'h1 : 2'h0;
        end
    end
    // Gate enables follow the switch state only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_pll_en <= 1'b1;
            sysclk_osc_en <= 1'b0;
        end else if (pclk_en) begin
            sysclk_pll_en <= sw_next == CKGEN_SW_PLL;
            sysclk_osc_en <= sw_next == CKGEN_SW_OSC;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference, PLL, CAN and clean oscillator outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_ref_ext       <= 1'b0;
            pll_enable        <= 1'b1;
            osc_enable        <= 1'b0;
            can_clk_en        <= 1'b0;
            osc_clean         <= 1'b0;
            internal_ref_trim <= TRIM_RST;
        end else if (pclk_en) begin
            osc_enable  <= osc_ctl_reg[`CKGEN_OSC_EN_BIT];
            pll_ref_ext <= osc_ctl_reg[`CKGEN_OSC_EN_BIT] & qualified;
            // Stays on in bypass so the VCO keeps clocking the filter
            pll_enable  <= 1'b1;
            // CAN runs on the oscillator alone, never the internal ref
            can_clk_en  <= osc_ctl_reg[`CKGEN_OSC_EN_BIT] &
                           qualified;
            osc_clean   <= filt_clean;
            internal_ref_trim <= {trim_hi_reg, trim_lo_reg};
        end
    end

endmodule

// [dv/ckgen_osc_model.sv]
// Crystal, VCO and lock pins seen by the clock generation unit.
// Assumes the bench commands lock loss through lock_kill.
`timescale 1ns/1ns
module ckgen_osc_model #(
    parameter int HALF = 2000
) (
    input  logic osc_on,
    input  logic lock_kill,
    output logic osc,
    output logic vco,
    output logic lock
);
    int k = 0;
    initial begin
        osc = 1'b0;
        vco = 1'b0;
    end
    // Crystal stands still while off; VCO runs at 8x
    always #(HALF / 8) begin
        vco = ~vco;
        k = (k + 1) % 8;
        if (k == 0) osc = osc_on ? ~osc : 1'b0;
    end
    // Lock falls only when a scenario asks for it
    assign lock = !lock_kill;
endmodule

// [dv/ckgen_top_chk.sv]
// Assertions on the clock generation unit's ports.
// Assumes one pclk domain, presetn its reset, pclk_en held high.
`timescale 1ns/1ns
module ckgen_top_chk #(
    parameter int          QUAL_EDGES = 8,
    parameter logic [15:0] TRIM_RST   = 16'h0200
) (
    input logic                      pclk,
    input logic                      presetn,
    input logic                      psel,
    input logic                      penable,
    input logic                      pready,
    input logic                      pll_lock_in,
    input ckgen_pkg::ckgen_pll_cfg_t pll_cfg,
    input logic                      pll_enable,
    input logic                      pll_ref_ext,
    input logic                      osc_enable,
    input logic [15:0]               internal_ref_trim,
    input logic                      sysclk_pll_en,
    input logic                      sysclk_osc_en,
    input logic [3:0]                debug_clk_div,
    input logic                      can_clk_en,
    input logic                      osc_clean
);
    import ckgen_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Both gates low: the switch never shortens a phase
    sequence s_gap;
        !sysclk_pll_en && !sysclk_osc_en;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_one_source: assert property (!(sysclk_pll_en && sysclk_osc_en))
        else $error("both clock gates open");
    a_gap_osc: assert property ($fell(sysclk_pll_en) |->
        s_gap [*2] ##[1:2] sysclk_osc_en) else $error("bad gap to osc");
    a_gap_pll: assert property ($fell(sysclk_osc_en) |->
        s_gap [*2] ##[1:2] sysclk_pll_en) else $error("bad gap to pll");
    a_rst_mode: assert property ($rose(presetn) |-> sysclk_pll_en &&
        !pll_ref_ext && !osc_enable) else $error("reset mode wrong");
    a_rst_cfg: assert property ($rose(presetn) |-> pll_cfg ==
        {6'h1f, 4'h0, 5'h03, 2'h0}) else $error("reset pll config");
    a_rst_dbg: assert property ($rose(presetn) |->
        debug_clk_div == 4'h2) else $error("reset debug divider");
    a_rst_trim: assert property ($rose(presetn) |->
        internal_ref_trim == TRIM_RST) else $error("reset trim");
    a_can_osc: assert property (can_clk_en |-> osc_enable)
        else $error("can clock without osc");
    a_filter_idle: assert property (!osc_enable [*3] |=>
        $stable(osc_clean) && !pll_ref_ext) else $error("filter active");
    a_pll_on: assert property (pll_enable)
        else $error("pll disabled");
    a_lock_qual: assert property ($fell(pll_lock_in) |->
        ##[1:8] !can_clk_en && !pll_ref_ext) else $error("qual kept");
    a_ready_once: assert property (psel && !penable |=>
        pready ##1 !pready) else $error("pready timing");
endmodule
bind ckgen_top ckgen_top_chk #(
    .QUAL_EDGES(QUAL_EDGES),
    .TRIM_RST(TRIM_RST)
) chk_u (.*);

// [dv/test_clock_gen_internal_ref_pll.sv]
// Self-checking bench for the clock generation unit over APB.
// Assumes ckgen_osc_model on the pins and the bound checker.
`timescale 1ns/1ns
`include "ckgen_regs.svh"
module test_clock_gen_internal_ref_pll;
    import ckgen_pkg::*;
    logic pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, pready, pslverr, slv, lk = 0, irq, osc_clean;
    logic osc_clock_in, vco_clock_in, pll_lock_in, pll_enable;
    logic pll_ref_ext, osc_enable, sysclk_pll_en, sysclk_osc_en;
    logic can_clk_en;
    logic [3:0] debug_clk_div;
    logic [7:0] paddr = 0;
    logic [15:0] internal_ref_trim;
    logic [31:0] pwdata = 0, prdata, q, d, r = 32'h4;
    logic [31:0] rv [7] = '{32'h1f, 0, 3, 0, 2, 0, 0};
    ckgen_pll_cfg_t pll_cfg;
    int err_total = 0, total_checks = 0, cyc = 0;
    ckgen_top #(.QUAL_EDGES(2)) dut_u (.*);
    ckgen_osc_model osc_u (.osc_on(osc_enable), .lock_kill(lk),
        .osc(osc_clock_in), .vco(vco_clock_in), .lock(pll_lock_in));
    ////////////////////////////////////////////////////////////////////
    // 10 MHz clock; cycle ceiling cuts a hang short
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        r ^= r << 13;
        r ^= r >> 17;
        r ^= r << 5;
        return r;
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready, the cycle ceiling ends a hang
    task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic waitq(logic v);
        do apb(0, 8'h24, 0); while (q[1] !== v);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'h30, 0);
        chk("dbgdiv", q, `CKGEN_DBGDIV_RST);
        apb(0, 8'h1c, 0);
        chk("clksel", q, 1);
        // Guarded writes must leave reset values; divider is free
        apb(1, 8'h20, 1);
        d = rnd();
        for (int i = 0; i < 7; i++) apb(1, 8'(i * 4), d);
        for (int i = 0; i < 7; i++) begin
            apb(0, 8'(i * 4), 0);
            chk("guarded", q, i == 2 ? d & 32'h1f : rv[i]);
        end
        chk("osc off", osc_enable, 0);
        apb(1, 8'h20, 0);
        // Trim rewrite with random values
        repeat (3) begin
            d = rnd();
            apb(1, 8'h10, d);
            apb(1, 8'h14, d >> 8);
            apb(0, 8'h10, 0);
            chk("trim_hi", q, d & 32'hff);
            @(negedge pclk);
            chk("trim", internal_ref_trim, {d[7:0], d[15:8]});
        end
        apb(0, 8'h40, 0);
        chk("slverr", slv, 1);
        chk("unmapped", q, 0);
        // Oscillator on, filter setting 8/2, then interrupt path
        apb(1, 8'h18, 32'h84);
        waitq(1);
        chk("can", can_clk_en, 1);
        d = osc_clean;
        repeat (30) if (osc_clean == d[0]) @(negedge pclk);
        chk("clean", osc_clean, !d[0]);
        chk("ref ext", pll_ref_ext, 1);
        chk("irq masked", irq, 0);
        apb(1, 8'h2c, 2);
        repeat (2) @(negedge pclk);
        chk("irq", irq, 1);
        apb(1, 8'h28, 2);
        repeat (2) @(negedge pclk);
        chk("irq clear", irq, 0);
        // Bypass, then lose lock while bypassed
        apb(1, 8'h1c, 0);
        repeat (8) @(negedge pclk);
        chk("osc clk", sysclk_osc_en, 1);
        chk("pll on", pll_enable, 1);
        lk <= 1;
        repeat (20) @(negedge pclk);
        chk("can lost", can_clk_en, 0);
        chk("pll back", sysclk_pll_en, 1);
        apb(0, 8'h1c, 0);
        chk("sel set", q, 1);
        apb(0, 8'h28, 0);
        chk("flags", q & 7, 5);
        lk <= 0;
        waitq(1);
        apb(1, 8'h18, 0);
        repeat (8) @(negedge pclk);
        chk("ext off", pll_ref_ext, 0);
        results();
    end
endmodule
